// ==== bench/pscfg_props.sv ====
// Port-level assertions for the pin select and floppy resource bank
`timescale 1ns/10ps
`default_nettype none

module pscfg_props
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic floppy_active,
	input wire logic io_valid,
	input wire logic [11:0] io_addr,
	input wire logic floppy_io_select,
	input wire logic floppy_irq_req,
	input wire logic floppy_drq_req,
	input wire logic [15:0] floppy_irq_lines,
	input wire logic [3:0] floppy_dma_req,
	input wire logic infrared_receive,
	input wire logic [7:0] serial_b_in,
	input wire logic [7:0] gp_io_group_four_in
);
	// ************************************************************
	// Bus timing and resource outputs
	// ************************************************************
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// A read inserts exactly one wait cycle; a write none
	sequence rd_taken;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence rd_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	read_wait_a: assert property (rd_taken |=> rd_wait)
		else $error("read wait cycle wrong");
	write_nowait_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
		else $error("write stalled");
	resp_okay_a: assert property (hresp == 1'h0)
		else $error("response not okay");
	rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	// Read data only moves when a read completes
	rdata_hold_a: assert property (!$rose(hreadyout) |-> $stable(hrdata))
		else $error("read data moved");
	idle_quiet_a: assert property (!floppy_active && !$past(floppy_active) |->
		!floppy_io_select && floppy_irq_lines == 16'h0 && floppy_dma_req == 4'h0)
		else $error("inactive controller drives resources");
	irq_zero_a: assert property (floppy_irq_lines[0] == 1'h0)
		else $error("irq line zero driven");
	line_onehot_a: assert property ($onehot0(floppy_irq_lines) && $onehot0(floppy_dma_req))
		else $error("several request lines high");
	irq_req_a: assert property (!$past(floppy_irq_req) |-> floppy_irq_lines == 16'h0)
		else $error("irq without request");
	dma_req_a: assert property (!$past(floppy_drq_req) |-> floppy_dma_req == 4'h0)
		else $error("dma without request");
	io_decode_a: assert property (floppy_io_select |-> $past(io_valid) && $past(io_addr) >= 12'h100)
		else $error("decode outside range");
	group_excl_a: assert property (serial_b_in != 8'h0 |-> !infrared_receive && gp_io_group_four_in == 8'h0)
		else $error("group functions overlap");
endmodule

`default_nettype wire

// ==== bench/test_pscfg_top.sv ====
// Self-checking bench for the pin select and floppy resource bank
`timescale 1ns/10ps
`default_nettype none

module test_pscfg_top;
	import pscfg_pkg::*;
	logic hclk = '0, hresetn = '0, resume_reset_n = '0, battery_reset_n = '0;
	logic hsel = '0, hwrite = '0, io_valid = '0, floppy_irq_req = '0, floppy_drq_req = '0;
	logic infrared_transmit = '0, hready, hreadyout, hresp, thermal_shutdown_enable;
	logic floppy_active, floppy_io_select, infrared_receive, rdy_q = 1'h1;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [11:0] io_addr = '0;
	logic [15:0] floppy_irq_lines;
	logic [3:0] floppy_dma_req;
	logic [7:0] grp_pin_in = '0, gp_io_group_four_out = '0, gp_io_group_four_oe = '0;
	logic [7:0] serial_b_out = '0, serial_b_oe = '0, sb_pin_in = '0, pm_func_out = '0;
	logic [7:0] pm_func_oe = '0, gp_io_bit_5x_out = '0, gp_io_bit_5x_oe = '0;
	logic [7:0] grp_pin_out, grp_pin_oe, gp_io_group_four_in, serial_b_in;
	logic [7:0] sb_pin_out, sb_pin_oe, pm_func_in, gp_io_bit_5x_in;
	int n_mismatch = 0, n_compared = 0;
	logic [31:0] exp_q[$];
	pscfg_byte_t idx_t[10] = '{8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'h50};
	pscfg_byte_t rst_t[10] = '{8'h00, 8'h21, 8'h00, 8'h00, 8'h01, 8'h03, 8'hF0, 8'h06, 8'h02, 8'h00};
	pscfg_byte_t msk_t[10] = '{8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h0F, 8'hF8, 8'h0F, 8'h07, 8'h00};

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;
	pscfg_top i_dut (.hclk, .hresetn, .resume_reset_n, .battery_reset_n, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
		.thermal_shutdown_enable, .floppy_active, .io_valid, .io_addr, .floppy_io_select,
		.floppy_irq_req, .floppy_drq_req, .floppy_irq_lines, .floppy_dma_req, .grp_pin_in,
		.grp_pin_out, .grp_pin_oe, .gp_io_group_four_out, .gp_io_group_four_oe,
		.gp_io_group_four_in, .infrared_transmit, .infrared_receive, .serial_b_out,
		.serial_b_oe, .serial_b_in, .sb_pin_in, .sb_pin_out, .sb_pin_oe, .pm_func_out,
		.pm_func_oe, .pm_func_in, .gp_io_bit_5x_out, .gp_io_bit_5x_oe, .gp_io_bit_5x_in);

	// 50 MHz clock
	always #10 hclk = ~hclk;

	// ************************************************************
	// Checking and bus tasks
	// ************************************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		// A read that never completed leaves its note behind
		if (exp_q.size() != 0)
			n_mismatch++;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Bounded wait so a stuck slave ends the run
	task automatic wait_rdy;
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'h1 && k < 20)
		begin
			@(posedge hclk);
			k++;
		end
		if (hreadyout !== 1'h1)
		begin
			n_mismatch++;
			report_and_stop();
		end
	endtask

	task automatic bus(input logic wr, input pscfg_byte_t idx, input pscfg_byte_t d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'h0};
		wait_rdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy();
	endtask

	task automatic rd(input pscfg_byte_t idx, input pscfg_byte_t e);
		exp_q.push_back({24'h0, e});
		bus(1'h0, idx, 8'h00);
	endtask

	// One-cycle reset pulse: 0 system, else standby
	task automatic pulse(input int w);
		@(posedge hclk);
		if (w == 0)
			hresetn <= 1'h0;
		else
			resume_reset_n <= 1'h0;
		@(posedge hclk);
		hresetn <= 1'h1;
		resume_reset_n <= 1'h1;
	endtask

	task automatic probe(input logic [11:0] a, input logic e);
		@(posedge hclk);
		io_valid <= 1'h1;
		io_addr <= a;
		@(posedge hclk);
		io_valid <= 1'h0;
		@(posedge hclk);
		check("io_select", floppy_io_select, e);
	endtask

	task automatic rnd;
		{gp_io_group_four_out, gp_io_group_four_oe, serial_b_out, serial_b_oe} <= $urandom;
		{pm_func_out, pm_func_oe, gp_io_bit_5x_out, gp_io_bit_5x_oe} <= $urandom;
		{grp_pin_in, sb_pin_in, infrared_transmit} <= 17'($urandom);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	// Read results are compared as each read completes
	always @(posedge hclk)
	begin
		if (hreadyout === 1'h1 && rdy_q === 1'h0 && exp_q.size() > 0)
			check("hrdata", hrdata, exp_q.pop_front());
		rdy_q <= hreadyout;
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		pscfg_byte_t v, eo, ee;
		void'($urandom(58));
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		resume_reset_n <= 1'h1;
		battery_reset_n <= 1'h1;
		for (int i = 0; i < 10; i++)
			rd(idx_t[i], rst_t[i]);
		check("active", floppy_active, 1'h1);
		done("reset values");
		for (int i = 0; i < 10; i++)
		begin
			v = 8'($urandom);
			bus(1'h1, idx_t[i], v);
			rd(idx_t[i], v & msk_t[i]);
		end
		bus(1'h1, 8'h2E, 8'h00);
		bus(1'h1, 8'h2F, 8'h00);
		done("read back");
		bus(1'h1, 8'h2D, 8'h5A);
		bus(1'h1, 8'h2C, 8'h07);
		pulse(0);
		rd(8'h2D, 8'h5A);
		rd(8'h2C, 8'h04);
		check("thermal", thermal_shutdown_enable, 1'h1);
		pulse(1);
		rd(8'h2D, 8'h21);
		rd(8'h30, 8'h01);
		done("reset domains");
		probe(12'h3EF, 1'h0);
		probe(12'h3F0, 1'h1);
		probe(12'h3F7, 1'h1);
		probe(12'h3F8, 1'h0);
		bus(1'h1, 8'h60, 8'h0F);
		bus(1'h1, 8'h61, 8'hF8);
		probe(12'hFFF, 1'h1);
		bus(1'h1, 8'h60, 8'h00);
		bus(1'h1, 8'h61, 8'h80);
		probe(12'h080, 1'h0);
		bus(1'h1, 8'h60, 8'h03);
		bus(1'h1, 8'h61, 8'hF0);
		bus(1'h1, 8'h30, 8'h00);
		probe(12'h3F0, 1'h0);
		bus(1'h1, 8'h30, 8'h01);
		done("io decode");
		floppy_irq_req <= 1'h1;
		floppy_drq_req <= 1'h1;
		for (int c = 0; c < 16; c++)
		begin
			bus(1'h1, 8'h70, 8'(c));
			repeat (3) @(posedge hclk);
			check("irq_lines", floppy_irq_lines, (c == 0) ? 16'h0 : 16'h1 << c);
			if (c < 8)
			begin
				bus(1'h1, 8'h74, 8'(c));
				repeat (3) @(posedge hclk);
				check("dma_req", floppy_dma_req, (c < 4) ? 4'h1 << c : 4'h0);
			end
		end
		bus(1'h1, 8'h74, 8'h01);
		bus(1'h1, 8'h30, 8'h00);
		repeat (3) @(posedge hclk);
		check("idle_req", {floppy_irq_lines, floppy_dma_req}, 20'h0);
		check("active", floppy_active, 1'h0);
		floppy_irq_req <= 1'h0;
		floppy_drq_req <= 1'h0;
		done("irq and dma");
		for (int c = 0; c < 4; c++)
		begin
			bus(1'h1, 8'h2C, 8'(c));
			rnd();
			repeat (4) @(posedge hclk);
			eo = (c == 3) ? serial_b_out : gp_io_group_four_out;
			ee = (c == 3) ? serial_b_oe : gp_io_group_four_oe;
			if (c < 2)
			begin
				eo[5] = (c == 1) & infrared_transmit;
				ee[5] = 1'h1;
				ee[4] = 1'h0;
			end
			check("grp_out", grp_pin_out & ee, eo & ee);
			check("grp_oe", grp_pin_oe, ee);
			check("ir_rx", infrared_receive, (c == 1) & grp_pin_in[4]);
			check("ser_in", serial_b_in, (c == 3) ? grp_pin_in : 8'h00);
			check("gp4_in", gp_io_group_four_in, (c == 3) ? 8'h00 : (c == 2) ? grp_pin_in : grp_pin_in & 8'hCF);
		end
		check("thermal", thermal_shutdown_enable, 1'h0);
		done("pin group");
		for (int i = 0; i < 3; i++)
		begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			bus(1'h1, 8'h2D, v);
			rnd();
			repeat (4) @(posedge hclk);
			ee = (v & gp_io_bit_5x_oe) | (~v & pm_func_oe);
			check("sb_oe", sb_pin_oe, ee);
			check("sb_out", sb_pin_out & ee, ((v & gp_io_bit_5x_out) | (~v & pm_func_out)) & ee);
			check("pm_in", pm_func_in, sb_pin_in & ~v);
			check("gp5x_in", gp_io_bit_5x_in, sb_pin_in & v);
		end
		done("standby pins");
		repeat (3) @(posedge hclk);
		report_and_stop();
	end
endmodule

bind pscfg_top pscfg_props i_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .hrdata, .hresp, .floppy_active, .io_valid, .io_addr, .floppy_io_select,
	.floppy_irq_req, .floppy_drq_req, .floppy_irq_lines, .floppy_dma_req, .infrared_receive,
	.serial_b_in, .gp_io_group_four_in);

`default_nettype wire

// ==== common/pscfg_map.svh ====
// Register indices, field positions, reset values and decode limits of the pin select bank
`ifndef PSCFG_MAP_SVH
`define PSCFG_MAP_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define PSCFG_IDX_GROUP 8'h2C
`define PSCFG_IDX_STANDBY 8'h2D
`define PSCFG_IDX_TEST_A 8'h2E
`define PSCFG_IDX_TEST_B 8'h2F
`define PSCFG_IDX_ACTIVATE 8'h30
`define PSCFG_IDX_BASE_HI 8'h60
`define PSCFG_IDX_BASE_LO 8'h61
`define PSCFG_IDX_IRQ 8'h70
`define PSCFG_IDX_DMA 8'h74

// ************************************************************
// Reset values
// ************************************************************
`define PSCFG_RST_GROUP 2'h0
`define PSCFG_RST_THERMAL 1'h0
`define PSCFG_RST_STANDBY 8'h21
`define PSCFG_RST_TEST 8'h00
`define PSCFG_RST_ACTIVATE 1'h1
`define PSCFG_RST_BASE_HI 8'h03
`define PSCFG_RST_BASE_LO 8'hF0
`define PSCFG_RST_IRQ 4'h6
`define PSCFG_RST_DMA 3'h2

// ************************************************************
// Field positions
// ************************************************************
`define PSCFG_BIT_THERMAL 2
`define PSCFG_BIT_ACTIVE 0
`define PSCFG_PIN_TRI 4
`define PSCFG_PIN_LOW 5

// ************************************************************
// Floppy decode limits
// ************************************************************
`define PSCFG_BASE_MIN 12'h100
`define PSCFG_BASE_MAX 12'hFF8

`endif

// ==== common/pscfg_pkg.sv ====
// Types shared by the pin select and floppy resource bank
package pscfg_pkg;
	// Function of the eight-pin group
	typedef enum logic [1:0]
	{
		GRP_LOW_TRI = 2'h0,
		GRP_INFRARED = 2'h1,
		GRP_ALL_GPIO = 2'h2,
		GRP_SERIAL_B = 2'h3
	} pscfg_grp_e;

	// Bus slave states, one-hot
	typedef enum logic [2:0]
	{
		BUS_IDLE = 3'h1,
		BUS_WRITE = 3'h2,
		BUS_READ = 3'h4
	} pscfg_bus_e;

	typedef logic [7:0] pscfg_byte_t;
endpackage

// ==== verilog/pscfg_pinroute.sv ====
// Pin routing for the eight-pin group and the eight standby pins
`timescale 1ns/10ps
`default_nettype none
`include "pscfg_map.svh"

module pscfg_pinroute
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire pscfg_pkg::pscfg_grp_e group_sel,
	input wire logic [7:0] standby_sel,
	input wire logic [7:0] grp_pin_in,
	output logic [7:0] grp_pin_out,
	output logic [7:0] grp_pin_oe,
	input wire logic [7:0] gp_io_group_four_out,
	input wire logic [7:0] gp_io_group_four_oe,
	output logic [7:0] gp_io_group_four_in,
	input wire logic infrared_transmit,
	output logic infrared_receive,
	input wire logic [7:0] serial_b_out,
	input wire logic [7:0] serial_b_oe,
	output logic [7:0] serial_b_in,
	input wire logic [7:0] sb_pin_in,
	output logic [7:0] sb_pin_out,
	output logic [7:0] sb_pin_oe,
	input wire logic [7:0] pm_func_out,
	input wire logic [7:0] pm_func_oe,
	output logic [7:0] pm_func_in,
	input wire logic [7:0] gp_io_bit_5x_out,
	input wire logic [7:0] gp_io_bit_5x_oe,
	output logic [7:0] gp_io_bit_5x_in
);
	import pscfg_pkg::*;

	logic [7:0] grp_meta_q, grp_sync_q, sb_meta_q, sb_sync_q;
	logic [7:0] grp_gpio_mask, grp_out_d, grp_oe_d;
	logic ir_active;

	// Pins are asynchronous: two flops before any logic looks at them
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			grp_meta_q <= 8'h00;
			grp_sync_q <= 8'h00;
			sb_meta_q <= 8'h00;
			sb_sync_q <= 8'h00;
		end
		else
		begin
			grp_meta_q <= grp_pin_in;
			grp_sync_q <= grp_meta_q;
			sb_meta_q <= sb_pin_in;
			sb_sync_q <= sb_meta_q;
		end
	end

	// Group decode: which pins stay general-purpose in each code
	assign ir_active = (group_sel == GRP_INFRARED);
	assign grp_gpio_mask = (group_sel == GRP_SERIAL_B) ? 8'h00 :
		(group_sel == GRP_ALL_GPIO) ? 8'hFF : 8'hCF;
	assign grp_out_d = (group_sel == GRP_SERIAL_B) ? serial_b_out :
		(gp_io_group_four_out & grp_gpio_mask) |
		(ir_active ? {2'h0, infrared_transmit, 5'h00} : 8'h00);
	// Code 00 parks pin A floating and drives pin B low
	assign grp_oe_d = (group_sel == GRP_SERIAL_B) ? serial_b_oe :
		(gp_io_group_four_oe & grp_gpio_mask) |
		((group_sel == GRP_LOW_TRI || ir_active) ? 8'h20 : 8'h00);

	// Registered pin drive keeps every output glitch free
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			grp_pin_out <= 8'h00;
			grp_pin_oe <= 8'h00;
			gp_io_group_four_in <= 8'h00;
			infrared_receive <= 1'b0;
			serial_b_in <= 8'h00;
			sb_pin_out <= 8'h00;
			sb_pin_oe <= 8'h00;
			pm_func_in <= 8'h00;
			gp_io_bit_5x_in <= 8'h00;
		end
		else
		begin
			grp_pin_out <= grp_out_d;
			grp_pin_oe <= grp_oe_d;
			gp_io_group_four_in <= grp_sync_q & grp_gpio_mask;
			infrared_receive <= ir_active & grp_sync_q[`PSCFG_PIN_TRI];
			serial_b_in <= (group_sel == GRP_SERIAL_B) ? grp_sync_q : 8'h00;
			// Clear bit picks the power function, set bit the GPIO
			sb_pin_out <= (pm_func_out & ~standby_sel) | (gp_io_bit_5x_out & standby_sel);
			sb_pin_oe <= (pm_func_oe & ~standby_sel) | (gp_io_bit_5x_oe & standby_sel);
			pm_func_in <= sb_sync_q & ~standby_sel;
			gp_io_bit_5x_in <= sb_sync_q & standby_sel;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/pscfg_top.sv ====
// Pin select and floppy resource configuration bank with an AHB-Lite slave
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pscfg_map.svh"

module pscfg_top
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic resume_reset_n,
	input wire logic battery_reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic thermal_shutdown_enable,
	output logic floppy_active,
	input wire logic io_valid,
	input wire logic [11:0] io_addr,
	output logic floppy_io_select,
	input wire logic floppy_irq_req,
	input wire logic floppy_drq_req,
	output logic [15:0] floppy_irq_lines,
	output logic [3:0] floppy_dma_req,
	input wire logic [7:0] grp_pin_in,
	output logic [7:0] grp_pin_out,
	output logic [7:0] grp_pin_oe,
	input wire logic [7:0] gp_io_group_four_out,
	input wire logic [7:0] gp_io_group_four_oe,
	output logic [7:0] gp_io_group_four_in,
	input wire logic infrared_transmit,
	output logic infrared_receive,
	input wire logic [7:0] serial_b_out,
	input wire logic [7:0] serial_b_oe,
	output logic [7:0] serial_b_in,
	input wire logic [7:0] sb_pin_in,
	output logic [7:0] sb_pin_out,
	output logic [7:0] sb_pin_oe,
	input wire logic [7:0] pm_func_out,
	input wire logic [7:0] pm_func_oe,
	output logic [7:0] pm_func_in,
	input wire logic [7:0] gp_io_bit_5x_out,
	input wire logic [7:0] gp_io_bit_5x_oe,
	output logic [7:0] gp_io_bit_5x_in
);
	import pscfg_pkg::*;

	// ************************************************************
	// Register storage
	// ************************************************************
	// Only implemented bits are stored, so reserved bits cannot hold state
	pscfg_grp_e group_q;
	logic thermal_q;
	pscfg_byte_t standby_q;
	pscfg_byte_t test_a_q;
	pscfg_byte_t test_b_q;
	logic active_q;
	logic [3:0] base_hi_q;
	logic [4:0] base_lo_q;
	logic [3:0] irq_sel_q;
	logic [2:0] dma_sel_q;

	// ************************************************************
	// Bus slave state
	// ************************************************************
	pscfg_bus_e bus_q, bus_d;
	logic [7:0] idx_q;
	logic [31:0] rdata_d;
	logic take;
	logic take_wr;
	logic take_rd;
	logic wr_now;
	logic [7:0] wbyte;

	// Map a register index onto its read value; reserved bits give zero
	function automatic logic [31:0] read_reg(input logic [7:0] idx, input pscfg_grp_e grp,
		input logic therm, input pscfg_byte_t sb, input pscfg_byte_t ta,
		input pscfg_byte_t tb, input logic act, input logic [3:0] bh,
		input logic [4:0] bl, input logic [3:0] irq, input logic [2:0] dma);
		logic [7:0] v;
		begin
			v = 8'h00;
			case (idx)
				`PSCFG_IDX_GROUP: v = {5'h00, therm, grp};
				`PSCFG_IDX_STANDBY: v = sb;
				`PSCFG_IDX_TEST_A: v = ta;
				`PSCFG_IDX_TEST_B: v = tb;
				`PSCFG_IDX_ACTIVATE: v = {7'h00, act};
				`PSCFG_IDX_BASE_HI: v = {4'h0, bh};
				`PSCFG_IDX_BASE_LO: v = {bl, 3'h0};
				`PSCFG_IDX_IRQ: v = {4'h0, irq};
				`PSCFG_IDX_DMA: v = {5'h00, dma};
				default: v = 8'h00;
			endcase
			read_reg = {24'h000000, v};
		end
	endfunction

	// Tell whether an index hits a write to a given register
	function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx,
		input logic en);
		begin
			hit = en && (idx == reg_idx);
		end
	endfunction

	// ************************************************************
	// Address phase decode
	// ************************************************************
	// Only NONSEQ and SEQ transfers with the bus ready are taken
	assign take = hsel && htrans[1] && hready;
	assign take_wr = take && hwrite;
	assign take_rd = take && !hwrite;
	assign wr_now = (bus_q == BUS_WRITE);
	assign wbyte = hwdata[7:0];
	assign rdata_d = read_reg(idx_q, group_q, thermal_q, standby_q, test_a_q, test_b_q,
		active_q, base_hi_q, base_lo_q, irq_sel_q, dma_sel_q);

	// Next state: reads insert one wait so the data comes from a flop
	always_comb
	begin
		bus_d = BUS_IDLE;
		case (bus_q)
			BUS_IDLE, BUS_WRITE:
			begin
				if (take_wr)
					bus_d = BUS_WRITE;
				else if (take_rd)
					bus_d = BUS_READ;
				else
					bus_d = BUS_IDLE;
			end
			BUS_READ: bus_d = BUS_IDLE;
			default: bus_d = BUS_IDLE;
		endcase
	end

	// Bus state, address capture and response
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bus_q <= BUS_IDLE;
			idx_q <= 8'h00;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end
		else
		begin
			bus_q <= bus_d;
			if (take)
				idx_q <= haddr[9:2];
			hreadyout <= !take_rd;
			hresp <= 1'b0;
			if (bus_q == BUS_READ)
				hrdata <= rdata_d;
		end
	end

	// ************************************************************
	// Battery domain
	// ************************************************************
	// Kept by its own reset so a system reset cannot drop the setting
	always_ff @(posedge hclk or negedge battery_reset_n)
	begin
		if (!battery_reset_n)
			thermal_q <= `PSCFG_RST_THERMAL;
		else if (hit(idx_q, `PSCFG_IDX_GROUP, wr_now))
			thermal_q <= wbyte[`PSCFG_BIT_THERMAL];
	end

	assign thermal_shutdown_enable = thermal_q;

	// ************************************************************
	// Standby domain
	// ************************************************************
	// Only the resume reset returns this register to its default
	always_ff @(posedge hclk or negedge resume_reset_n)
	begin
		if (!resume_reset_n)
			standby_q <= `PSCFG_RST_STANDBY;
		else if (hit(idx_q, `PSCFG_IDX_STANDBY, wr_now))
			standby_q <= wbyte;
	end

	// ************************************************************
	// System reset domain
	// ************************************************************
	// Group select and test registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			group_q <= pscfg_grp_e'(`PSCFG_RST_GROUP);
			test_a_q <= `PSCFG_RST_TEST;
			test_b_q <= `PSCFG_RST_TEST;
		end
		else
		begin
			if (hit(idx_q, `PSCFG_IDX_GROUP, wr_now))
				group_q <= pscfg_grp_e'(wbyte[1:0]);
			if (hit(idx_q, `PSCFG_IDX_TEST_A, wr_now))
				test_a_q <= wbyte;
			if (hit(idx_q, `PSCFG_IDX_TEST_B, wr_now))
				test_b_q <= wbyte;
		end
	end

	// Floppy resources; unwritable bits are never stored
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			active_q <= `PSCFG_RST_ACTIVATE;
			base_hi_q <= 4'(`PSCFG_RST_BASE_HI);
			base_lo_q <= 5'(`PSCFG_RST_BASE_LO >> 3); // Only address bits 7:3 are stored
			irq_sel_q <= `PSCFG_RST_IRQ;
			dma_sel_q <= `PSCFG_RST_DMA;
		end
		else
		begin
			if (hit(idx_q, `PSCFG_IDX_ACTIVATE, wr_now))
				active_q <= wbyte[`PSCFG_BIT_ACTIVE];
			if (hit(idx_q, `PSCFG_IDX_BASE_HI, wr_now))
				base_hi_q <= wbyte[3:0];
			if (hit(idx_q, `PSCFG_IDX_BASE_LO, wr_now))
				base_lo_q <= wbyte[7:3];
			if (hit(idx_q, `PSCFG_IDX_IRQ, wr_now))
				irq_sel_q <= wbyte[3:0];
			if (hit(idx_q, `PSCFG_IDX_DMA, wr_now))
				dma_sel_q <= wbyte[2:0];
		end
	end

	// ************************************************************
	// Floppy resource decode
	// ************************************************************
	logic [11:0] base_addr;
	logic base_legal;
	logic io_hit;
	logic [15:0] irq_onehot;
	logic [3:0] dma_onehot;

	// A base below the legal window decodes nothing rather than alias
	assign base_addr = {base_hi_q, base_lo_q, 3'h0};
	assign base_legal = (base_addr >= `PSCFG_BASE_MIN) && (base_addr <= `PSCFG_BASE_MAX);
	assign io_hit = io_valid && base_legal && (io_addr[11:3] == base_addr[11:3]);
	// IRQ code zero selects no line, so a cleared IRQ register is harmless; DMA codes 4 to 7 select none
	assign irq_onehot = (irq_sel_q == 4'h0) ? 16'h0000 : (16'h0001 << irq_sel_q);
	assign dma_onehot = dma_sel_q[2] ? 4'h0 : (4'h1 << dma_sel_q[1:0]);

	// Registered resource outputs, all held off while inactive
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			floppy_active <= 1'b0;
			floppy_io_select <= 1'b0;
			floppy_irq_lines <= 16'h0000;
			floppy_dma_req <= 4'h0;
		end
		else
		begin
			floppy_active <= active_q;
			floppy_io_select <= active_q && io_hit;
			floppy_irq_lines <= (active_q && floppy_irq_req) ? irq_onehot : 16'h0000;
			floppy_dma_req <= (active_q && floppy_drq_req) ? dma_onehot : 4'h0;
		end
	end

	// ************************************************************
	// Pin routing
	// ************************************************************
	pscfg_pinroute u_pinroute
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.group_sel(group_q),
		.standby_sel(standby_q),
		.grp_pin_in(grp_pin_in),
		.grp_pin_out(grp_pin_out),
		.grp_pin_oe(grp_pin_oe),
		.gp_io_group_four_out(gp_io_group_four_out),
		.gp_io_group_four_oe(gp_io_group_four_oe),
		.gp_io_group_four_in(gp_io_group_four_in),
		.infrared_transmit(infrared_transmit),
		.infrared_receive(infrared_receive),
		.serial_b_out(serial_b_out),
		.serial_b_oe(serial_b_oe),
		.serial_b_in(serial_b_in),
		.sb_pin_in(sb_pin_in),
		.sb_pin_out(sb_pin_out),
		.sb_pin_oe(sb_pin_oe),
		.pm_func_out(pm_func_out),
		.pm_func_oe(pm_func_oe),
		.pm_func_in(pm_func_in),
		.gp_io_bit_5x_out(gp_io_bit_5x_out),
		.gp_io_bit_5x_oe(gp_io_bit_5x_oe),
		.gp_io_bit_5x_in(gp_io_bit_5x_in)
	);

	// hsize is accepted for every access; the bank is word-only
	logic unused_ok;
	assign unused_ok = &{1'b0, hsize, haddr[31:10], haddr[1:0], hwdata[31:8]};
endmodule
`default_nettype wire
